// ===== design/tsc_pkg.sv
// Package for the timestamp counter block: register map, field encodings, reset values and timing figures.
// Assumes a 25 MHz system clock and a plain strobe register port on the camera control bus.
package tsc_pkg;

   // Clock rate and internal tick base.
   localparam int unsigned CLK_HZ          = 25000000;
   localparam int unsigned TICK_NS         = 1000;
   localparam int unsigned TICK_HZ         = 1000000000 / TICK_NS;
   localparam int unsigned TICK_CYCLES     = (CLK_HZ / 1000000) * TICK_NS / 1000;
   localparam logic [4:0]  TICK_DIV_LAST   = 5'(TICK_CYCLES - 1);

   // Register byte addresses.
   localparam logic [7:0] ADDR_CONTROL     = 8'h00;
   localparam logic [7:0] ADDR_COMMAND     = 8'h04;
   localparam logic [7:0] ADDR_CAPT_LO     = 8'h08;
   localparam logic [7:0] ADDR_CAPT_HI     = 8'h0c;
   localparam logic [7:0] ADDR_TICKS_SEC   = 8'h10;
   localparam logic [7:0] ADDR_COUNT_LO    = 8'h14;
   localparam logic [7:0] ADDR_COUNT_HI    = 8'h18;

   // Control register field positions.
   localparam int unsigned CTL_INC_LSB     = 0;
   localparam int unsigned CTL_CAPEDGE_LSB = 2;
   localparam int unsigned CTL_CAPSRC_BIT  = 4;
   localparam int unsigned CTL_CLRSRC_BIT  = 5;
   localparam int unsigned CTL_CLREDGE_LSB = 6;

   // Command register bit positions.
   localparam int unsigned CMD_CAPTURE_BIT = 0;
   localparam int unsigned CMD_CLEAR_BIT   = 1;

   // Reset values.
   localparam logic [7:0]  CONTROL_RESET   = 8'h00;
   localparam logic [63:0] COUNT_RESET     = 64'h0;

   // Ticks per second reported for external sources, which have no fixed rate.
   localparam logic [31:0] EXT_TICKS_SEC   = 32'h0;

   typedef enum logic [1:0] {
      TSC_INC_CAMERA_CLOCK_TICKS  = 2'b00,
      TSC_INC_INPUT_LINE_TWO      = 2'b01,
      TSC_INC_EXPOSURE_BEGIN      = 2'b10
   } tsc_inc_e;

   typedef enum logic [1:0] {
      TSC_EDGE_DOWN               = 2'b00,
      TSC_EDGE_UP                 = 2'b01,
      TSC_EDGE_EITHER             = 2'b10
   } tsc_edge_e;

endpackage : tsc_pkg

// ===== design/tsc_timestamp_counter.sv
// Timestamp counter with software and event capture, and software and line-driven clear.
// Assumes the line and exposure/frame inputs are asynchronous and a same-clock register master.
//
// Our own choices: the plain strobed port and the address map.

// Behaviour
// (R01) Capture command copies running count to holding register.
// (R02) Captured value is 64 bits, per increment source.
// (R03) Count ticks from clock, line two, or exposure.
// (R04) Line capture on down, up or either edge; the code captures on line edges only while line two is the increment source.
// (R05) Report ticks per second, tracking increment source.
// (R06) Frame-begin capture source captures at each frame.
// (R07) Clear command zeroes the counter.
// (R08) Software disables timing protocol before clearing it.
// (R09) Clear command works with no hardware clear source.
// (R10) Clear source is line two or none.
// (R11) Line clear on down, up or either edge.
// (R12) Holding register keeps value until next capture.
module tsc_timestamp_counter (
   // Clock and reset
   input  wire logic        i_ref_clk,
   input  wire logic        i_srst,
   // Register port
   input  wire logic [7:0]  i_addr,
   input  wire logic [31:0] i_wdata,
   input  wire logic        i_wr,
   input  wire logic        i_rd,
   output      logic [31:0] o_rdata,
   // Camera event inputs
   input  wire logic        i_input_line_two,
   input  wire logic        i_exposure_begin_event,
   input  wire logic        i_frame_begin_event,
   // Status
   output      logic [63:0] o_captured_count_value
);

   logic [1:0]  line_sync;
   logic [1:0]  expo_sync;
   logic [1:0]  frame_sync;
   logic        line_d;
   logic        expo_d;
   logic        frame_d;
   logic [7:0]  control;
   logic [4:0]  div_cnt;
   logic [63:0] count;
   logic [63:0] captured;
   logic [31:0] rdata;

   logic [7:0]  next_control;
   logic [4:0]  next_div_cnt;
   logic [63:0] next_count;
   logic [63:0] next_captured;
   logic [31:0] next_rdata;

   logic        line_rise;
   logic        line_fall;
   logic        expo_rise;
   logic        frame_rise;
   logic        tick_en;
   logic        inc;
   logic        cap_sw;
   logic        cap_line;
   logic        cap_evt;
   logic        clr_sw;
   logic        clr_line;
   logic [1:0]  inc_sel;
   logic [1:0]  cap_edge;
   logic [1:0]  clr_edge;
   logic [31:0] ticks_sec;

   // Every external event passes two flip-flops; edges are found on the second stage only.
   always_ff @(posedge i_ref_clk) begin
      if (i_srst) begin
         line_sync  <= 2'h0;
         expo_sync  <= 2'h0;
         frame_sync <= 2'h0;
         line_d     <= 1'h0;
         expo_d     <= 1'h0;
         frame_d    <= 1'h0;
      end else begin
         line_sync  <= {line_sync[0], i_input_line_two};
         expo_sync  <= {expo_sync[0], i_exposure_begin_event};
         frame_sync <= {frame_sync[0], i_frame_begin_event};
         line_d     <= line_sync[1];
         expo_d     <= expo_sync[1];
         frame_d    <= frame_sync[1];
      end
   end

   always_comb begin
      inc_sel    = control[tsc_pkg::CTL_INC_LSB +: 2];
      cap_edge   = control[tsc_pkg::CTL_CAPEDGE_LSB +: 2];
      clr_edge   = control[tsc_pkg::CTL_CLREDGE_LSB +: 2];
      line_rise  = line_sync[1] & ~line_d;
      line_fall  = ~line_sync[1] & line_d;
      expo_rise  = expo_sync[1] & ~expo_d;
      frame_rise = frame_sync[1] & ~frame_d;
      tick_en    = (div_cnt == tsc_pkg::TICK_DIV_LAST);
      // Selected increment source.
      unique case (inc_sel)
         tsc_pkg::TSC_INC_CAMERA_CLOCK_TICKS: inc = tick_en; // (R03)
         tsc_pkg::TSC_INC_INPUT_LINE_TWO:     inc = line_rise; // (R03)
         tsc_pkg::TSC_INC_EXPOSURE_BEGIN:     inc = expo_rise; // (R03)
         default:                             inc = 1'b0;
      endcase
      // Line capture only applies while line two drives the count.
      unique case (cap_edge)
         tsc_pkg::TSC_EDGE_DOWN:   cap_line = line_fall; // (R04)
         tsc_pkg::TSC_EDGE_UP:     cap_line = line_rise; // (R04)
         tsc_pkg::TSC_EDGE_EITHER: cap_line = line_rise | line_fall; // (R04)
         default:                  cap_line = 1'b0;
      endcase
      cap_line = cap_line & (inc_sel == tsc_pkg::TSC_INC_INPUT_LINE_TWO);
      unique case (clr_edge)
         tsc_pkg::TSC_EDGE_DOWN:   clr_line = line_fall; // (R11)
         tsc_pkg::TSC_EDGE_UP:     clr_line = line_rise; // (R11)
         tsc_pkg::TSC_EDGE_EITHER: clr_line = line_rise | line_fall; // (R11)
         default:                  clr_line = 1'b0;
      endcase
      clr_line = clr_line & control[tsc_pkg::CTL_CLRSRC_BIT]; // (R10)
      cap_evt  = frame_rise & control[tsc_pkg::CTL_CAPSRC_BIT]; // (R06)
      cap_sw   = i_wr & (i_addr == tsc_pkg::ADDR_COMMAND) & i_wdata[tsc_pkg::CMD_CAPTURE_BIT];
      clr_sw   = i_wr & (i_addr == tsc_pkg::ADDR_COMMAND) & i_wdata[tsc_pkg::CMD_CLEAR_BIT];
      // Only the internal tick has a known rate; external sources report zero.
      ticks_sec = (inc_sel == tsc_pkg::TSC_INC_CAMERA_CLOCK_TICKS) ? 32'(tsc_pkg::TICK_HZ)
                                                                  : tsc_pkg::EXT_TICKS_SEC; // (R05)
   end

   always_comb begin
      next_control  = control;
      next_div_cnt  = tick_en ? 5'h00 : 5'(div_cnt + 5'h01);
      next_count    = count;
      next_captured = captured; // (R12)
      next_rdata    = 32'h0;
      if (i_wr && (i_addr == tsc_pkg::ADDR_CONTROL)) begin
         next_control = i_wdata[7:0];
      end
      // Clear outranks increment; the software command acts regardless of the clear source.
      if (clr_sw || clr_line) begin
         next_count   = tsc_pkg::COUNT_RESET; // (R07) (R09)
         next_div_cnt = 5'h00;
      end else if (inc) begin
         next_count = 64'(count + 64'h1);
      end
      // Capture sees the count before this cycle's update, so the value is the one present at the command.
      if (cap_sw || cap_line || cap_evt) begin
         next_captured = count; // (R01) (R02)
      end
      if (i_rd) begin
         unique case (i_addr)
            tsc_pkg::ADDR_CONTROL:   next_rdata = {24'h0, control};
            tsc_pkg::ADDR_CAPT_LO:   next_rdata = captured[31:0]; // (R02)
            tsc_pkg::ADDR_CAPT_HI:   next_rdata = captured[63:32]; // (R02)
            tsc_pkg::ADDR_TICKS_SEC: next_rdata = ticks_sec; // (R05)
            tsc_pkg::ADDR_COUNT_LO:  next_rdata = count[31:0];
            tsc_pkg::ADDR_COUNT_HI:  next_rdata = count[63:32];
            default:                 next_rdata = 32'h0;
         endcase
      end
   end

   always_ff @(posedge i_ref_clk) begin
      if (i_srst) begin
         control  <= tsc_pkg::CONTROL_RESET;
         div_cnt  <= 5'h00;
         count    <= tsc_pkg::COUNT_RESET;
         captured <= tsc_pkg::COUNT_RESET;
         rdata    <= 32'h0;
      end else begin
         control  <= next_control;
         div_cnt  <= next_div_cnt;
         count    <= next_count;
         captured <= next_captured;
         rdata    <= next_rdata;
      end
   end

   assign o_rdata                = rdata;
   assign o_captured_count_value = captured;

endmodule // tsc_timestamp_counter

// ===== verif/testbench.sv
// Self-checking bench for the timestamp counter, driving every port directly.
// Assumes a 40 ns clock; read results are queued by the driver and checked by a monitor.
module testbench;
   timeunit 1ns;
   timeprecision 1ns;
`define CHK(a, e) begin check_count++; if ((a) !== (e)) begin failures++; $display("unexpected t=%0t got %h exp %h", $time, a, e); end end
   logic i_ref_clk = 1'h0, i_srst = 1'h1, i_wr = 1'h0, i_rd = 1'h0, rd_seen = 1'h0;
   logic i_input_line_two = 1'h0, i_exposure_begin_event = 1'h0, i_frame_begin_event = 1'h0;
   logic [7:0]  i_addr = 8'h0;
   logic [31:0] i_wdata = 32'h0, o_rdata, e;
   logic [63:0] o_captured_count_value;
   logic [31:0] exp_q[$];
   int          failures = 0, check_count = 0, seed = 87;
   always #20 i_ref_clk = ~i_ref_clk;
   tsc_timestamp_counter tsc_timestamp_counter_i (.i_ref_clk(i_ref_clk), .i_srst(i_srst), .i_addr(i_addr),
      .i_wdata(i_wdata), .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata), .i_input_line_two(i_input_line_two),
      .i_exposure_begin_event(i_exposure_begin_event), .i_frame_begin_event(i_frame_begin_event),
      .o_captured_count_value(o_captured_count_value));
   // Each access task drives both strobes and w drops them when the bus goes idle, so back-to-back accesses never assign a strobe twice in one step.
   task w(input int n); i_wr <= 1'h0; i_rd <= 1'h0; repeat (n) @(posedge i_ref_clk); endtask
   task wr(input logic [7:0] a, input logic [31:0] d);
      i_addr <= a; i_wdata <= d; i_rd <= 1'h0; i_wr <= 1'h1; @(posedge i_ref_clk);
   endtask
   task rd(input logic [7:0] a, input logic [31:0] x);
      exp_q.push_back(x); i_addr <= a; i_wr <= 1'h0; i_rd <= 1'h1; @(posedge i_ref_clk);
   endtask
   task cap(input logic [31:0] x); wr(tsc_pkg::ADDR_COMMAND, 32'h1); rd(tsc_pkg::ADDR_CAPT_LO, x); endtask
   // Short random halves keep a two-edge pulse inside one internal tick period.
   task pulse(input logic [2:0] m);
      int g;
      g = 8 + ($unsigned($random(seed)) % 4);
      {i_frame_begin_event, i_exposure_begin_event, i_input_line_two} <= m; w(g);
      {i_frame_begin_event, i_exposure_begin_event, i_input_line_two} <= 3'h0; w(g);
   endtask
   task give_verdict;
      $display("failures=%0d check_count=%0d", failures, check_count);
      if (failures == 0 && check_count > 0) $display("ALL CHECKS OK");
      else $display("CHECKS NOT OK");
      $finish;
   endtask
   always @(posedge i_ref_clk) rd_seen <= i_rd;
   always @(negedge i_ref_clk) if (rd_seen === 1'h1) begin
      e = exp_q.pop_front();
      `CHK(o_rdata, e)
   end
   initial begin
      repeat (5000) @(posedge i_ref_clk);
      failures++; give_verdict;
   end
   initial begin
      w(2); i_srst <= 1'h0; w(1);
      rd(tsc_pkg::ADDR_CONTROL, 32'h0); rd(tsc_pkg::ADDR_CAPT_HI, 32'h0); rd(8'h1c, 32'h0);
      for (int s = 0; s < 3; s++) begin
         wr(tsc_pkg::ADDR_CONTROL, 32'(s));
         rd(tsc_pkg::ADDR_TICKS_SEC, s == 0 ? 32'(tsc_pkg::TICK_HZ) : tsc_pkg::EXT_TICKS_SEC);
      end
      wr(tsc_pkg::ADDR_CONTROL, 32'h0); wr(tsc_pkg::ADDR_COMMAND, 32'h2); cap(32'h0);
      w(105); cap(32'h4);
      for (int m = 1; m < 3; m++) begin
         wr(tsc_pkg::ADDR_CONTROL, 32'(m)); wr(tsc_pkg::ADDR_COMMAND, 32'h2);
         repeat (3) pulse(3'(m));
         cap(32'h3);
      end
      wr(tsc_pkg::ADDR_CONTROL, 32'h1); wr(tsc_pkg::ADDR_COMMAND, 32'h2);
      for (int k = 0; k < 3; k++) begin
         wr(tsc_pkg::ADDR_CONTROL, 32'(1 | k << 2)); pulse(3'h1);
         rd(tsc_pkg::ADDR_CAPT_LO, k == 2 ? 32'h3 : 32'h1);
      end
      for (int k = 0; k < 3; k++) begin
         wr(tsc_pkg::ADDR_CONTROL, 32'(8'h20 | k << 6)); w(60); pulse(3'h1);
         cap(32'h0);
      end
      wr(tsc_pkg::ADDR_CONTROL, 32'h10); wr(tsc_pkg::ADDR_COMMAND, 32'h2);
      rd(tsc_pkg::ADDR_COUNT_LO, 32'h0); rd(tsc_pkg::ADDR_COUNT_HI, 32'h0);
      w(60); pulse(3'h5);
      rd(tsc_pkg::ADDR_CAPT_LO, 32'h2);
      w(40); rd(tsc_pkg::ADDR_CAPT_LO, 32'h2);
      `CHK(o_captured_count_value, 64'h2)
      w(3); give_verdict;
   end
endmodule // testbench

// ===== verif/tsc_props.sv
// Checker for the timestamp counter, seeing only the ports of its top module.
// Assumes one clock and the control and address encodings of the package.
module tsc_props (
   input wire logic        i_ref_clk,
   input wire logic        i_srst,
   input wire logic [7:0]  i_addr,
   input wire logic [31:0] i_wdata,
   input wire logic        i_wr,
   input wire logic        i_rd,
   input wire logic [31:0] o_rdata,
   input wire logic        i_input_line_two,
   input wire logic        i_frame_begin_event,
   input wire logic [63:0] o_captured_count_value
);
   default clocking cb @(posedge i_ref_clk); endclocking
   default disable iff (i_srst);
   logic [7:0]  ctl;
   logic [3:0]  quiet;
   logic [63:0] cap_q;
   wire cmd_w = i_wr && i_addr == tsc_pkg::ADDR_COMMAND;
   wire inc0 = ctl[1:0] == tsc_pkg::TSC_INC_CAMERA_CLOCK_TICKS;
   // Events reach the logic through synchronisers, so the quiet span must outlast them.
   always_ff @(posedge i_ref_clk) begin
      cap_q <= o_captured_count_value;
      if (i_srst) ctl <= 8'h0;
      else if (i_wr && i_addr == tsc_pkg::ADDR_CONTROL) ctl <= i_wdata[7:0];
      if (i_srst || cmd_w || $changed(i_input_line_two) || $changed(i_frame_begin_event)) quiet <= 4'h0;
      else if (quiet != 4'h8) quiet <= quiet + 4'h1;
   end
   property p_hold; quiet == 4'h8 |-> $stable(o_captured_count_value); endproperty
   a_hold: assert property (p_hold) else $error("held value moved");
   property p_cap_lo; i_rd && i_addr == tsc_pkg::ADDR_CAPT_LO |=> o_rdata == cap_q[31:0]; endproperty
   a_cap_lo: assert property (p_cap_lo) else $error("low word wrong");
   property p_cap_hi; i_rd && i_addr == tsc_pkg::ADDR_CAPT_HI |=> o_rdata == cap_q[63:32]; endproperty
   a_cap_hi: assert property (p_cap_hi) else $error("high word wrong");
   property p_tps;
      i_rd && i_addr == tsc_pkg::ADDR_TICKS_SEC |=> o_rdata == (inc0 ? tsc_pkg::TICK_HZ : tsc_pkg::EXT_TICKS_SEC);
   endproperty
   a_tps: assert property (p_tps) else $error("tick rate wrong");
   property p_clr; cmd_w && i_wdata[1] && inc0 ##1 i_rd && i_addr == tsc_pkg::ADDR_COUNT_LO |=> o_rdata == 32'h0; endproperty
   a_clr: assert property (p_clr) else $error("count not cleared");
   property p_clr_cap; cmd_w && i_wdata[1] && inc0 ##1 cmd_w && i_wdata[0] |=> o_captured_count_value == 64'h0; endproperty
   a_clr_cap: assert property (p_clr_cap) else $error("capture after clear not zero");
   property p_unmapped; i_rd && i_addr > tsc_pkg::ADDR_COUNT_HI |=> o_rdata == 32'h0; endproperty
   a_unmapped: assert property (p_unmapped) else $error("unmapped read not zero");
   property p_idle; !i_rd |=> o_rdata == 32'h0; endproperty
   a_idle: assert property (p_idle) else $error("read data outside its cycle");
   c_cap: cover property (cmd_w && i_wdata[0]);
   c_tps: cover property (i_rd && i_addr == tsc_pkg::ADDR_TICKS_SEC && !inc0);
   c_hold: cover property (quiet == 4'h8 && ctl[4]);
endmodule // tsc_props
bind tsc_timestamp_counter tsc_props tsc_props_i (.i_ref_clk(i_ref_clk), .i_srst(i_srst), .i_addr(i_addr),
   .i_wdata(i_wdata), .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata), .i_input_line_two(i_input_line_two),
   .i_frame_begin_event(i_frame_begin_event), .o_captured_count_value(o_captured_count_value));
